// *** rtc_pkg.sv ***
// Register map, field layout, reset values and counts of the calendar clock control block
package rtc_pkg;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [31:0] FLAGS_ADDR = 32'hE002_4000;
  localparam logic [31:0] TICK_COUNT_ADDR = 32'hE002_4004;
  localparam logic [31:0] CONTROL_ADDR = 32'hE002_4008;
  localparam logic [31:0] IRQ_ENABLE_ADDR = 32'hE002_400C;
  localparam logic [31:0] MASK_ADDR = 32'hE002_4010;
  localparam logic [31:0] PACKED_TIME_LOW_ADDR = 32'hE002_4014;
  localparam logic [31:0] PACKED_DATE_ADDR = 32'hE002_4018;
  localparam logic [31:0] PACKED_YEAR_DAY_ADDR = 32'hE002_401C;

  // ----------------------------------------------------------------
  // Bus constants
  // ----------------------------------------------------------------
  localparam logic [2:0] WORD_SIZE = 3'h2;

  // ----------------------------------------------------------------
  // Tick divider control fields
  // ----------------------------------------------------------------
  localparam int CONTROL_W = 5;
  localparam int RUN_ENABLE_BIT = 0;
  localparam int TICK_CLEAR_BIT = 1;
  localparam int TEST_FIELD_LSB = 2;
  localparam int TEST_FIELD_W = 2;
  localparam int SOURCE_SELECT_BIT = 4;

  // ----------------------------------------------------------------
  // Interrupt source flags
  // ----------------------------------------------------------------
  localparam int FLAGS_W = 2;
  localparam int FLAG_INC_BIT = 0;
  localparam int FLAG_ALARM_BIT = 1;

  // ----------------------------------------------------------------
  // Counter order, widths and packed positions
  // ----------------------------------------------------------------
  localparam int COUNTERS = 8;
  localparam int VALUE_W = 12;
  localparam int SEC_W = 6;
  localparam int MIN_W = 6;
  localparam int HOUR_W = 5;
  localparam int DOM_W = 5;
  localparam int DOW_W = 3;
  localparam int DOY_W = 9;
  localparam int MON_W = 4;
  localparam int YEAR_W = 12;
  localparam int SEC_LSB = 0;
  localparam int MIN_LSB = 8;
  localparam int HOUR_LSB = 16;
  localparam int DOW_LSB = 24;
  localparam int DOM_LSB = 0;
  localparam int MON_LSB = 8;
  localparam int YEAR_LSB = 16;
  localparam int DOY_LSB = 0;

  // ----------------------------------------------------------------
  // Sub-second tick counter and reset values
  // ----------------------------------------------------------------
  localparam int TICK_W = 15;
  localparam int TICK_LSB = 1;
  localparam logic [14:0] TICK_LAST = 15'h7FFF;
  localparam logic [4:0] CONTROL_RESET = 5'h00;
  localparam logic [7:0] IRQ_ENABLE_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'h00;

  typedef logic [11:0] value_t;

endpackage : rtc_pkg

// *** alarm_link_if.sv ***
// Carrier between the control block and its alarm comparator
`timescale 1ns/1ns
interface alarm_link_if;
  rtc_pkg::value_t now_val [rtc_pkg::COUNTERS];
  rtc_pkg::value_t al_val [rtc_pkg::COUNTERS];
  logic [7:0] mask;
  logic match;
  logic rise;

  modport source (output now_val, output al_val, output mask, input match, input rise);
  modport cmp (input now_val, input al_val, input mask, output match, output rise);
endinterface : alarm_link_if

// *** alarm_compare.sv ***
// Masked alarm compare with mismatch-to-match edge detection
`timescale 1ns/1ns
module alarm_compare (
  input wire logic clk_i,
  input wire logic rst_n_i,
  alarm_link_if.cmp lnk
);

  logic [7:0] differ;
  logic match;
  logic prev_match;
  logic next_prev_match;

  // Per-counter compare; masked counters never block the match unless all eight are masked
  always_comb begin
    for (int i = 0; i < rtc_pkg::COUNTERS; i++) begin
      differ[i] = lnk.now_val[i] != lnk.al_val[i];
    end
    match = ((differ & ~lnk.mask) == 8'h00) && !(&lnk.mask);
    next_prev_match = match;
  end

  assign lnk.match = match;
  assign lnk.rise = match && !prev_match;

  // Previous compare result
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prev_match <= 1'b0;
    end else begin
      prev_match <= next_prev_match;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  match_needs_equal_a: assert property (lnk.match |-> (differ & ~lnk.mask) == 8'h00)
    else $error("Alarm match with an unmasked counter differing");
  mask_excludes_a: assert property (((differ & ~lnk.mask) == 8'h00) && !(&lnk.mask) |-> lnk.match)
    else $error("Masked counter blocked the alarm match");
  all_masked_a: assert property (&lnk.mask |-> !lnk.match && !lnk.rise)
    else $error("Alarm raised with every counter masked");
  rise_once_a: assert property (lnk.match ##1 lnk.match |-> !lnk.rise)
    else $error("Alarm event repeated while match persisted");
  alarm_rise_c: cover property (lnk.rise);

endmodule : alarm_compare

// *** rtc_control.sv ***
// Calendar clock control, interrupt flags, alarm mask and packed time readout
`timescale 1ns/1ns
//
// Overview of operation
// - Run enable one lets time counters advance
// - Tick clear holds tick counter at zero
// - Source select picks prescaler or slow oscillator
// - Tick divider control register is five bits
// - Enabled counter increments raise increment interrupt
// - Increment flag stays until written one
// - Alarm matches when unmasked counters all equal
// - Alarm fires only on mismatch-to-match edge
// - Alarm flag stays until written one
// - Mask bit one excludes that counter
// - All mask bits set disables alarm
// - Packed time words are read only
// - Word zero: seconds, minutes, hours, week day
// - Word one: month day, month, year
// - Reserved packed bits undefined; software writes zero
// - Writing one clears flag, zero leaves it
// - Word two: year day in bits 8:0
// - Alarm flag set on entry into match; increment flag set in every cycle with an enabled increment
module rtc_control (
  input wire logic REF_CLK_I,
  input wire logic RST_N_I,
  input wire logic HSEL_I,
  input wire logic [31:0] HADDR_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic [2:0] HSIZE_I,
  input wire logic [31:0] HWDATA_I,
  input wire logic HREADY_I,
  output logic [31:0] HRDATA_O,
  output logic HREADYOUT_O,
  output logic HRESP_O,
  input wire logic PRESCALE_TICK_I,
  input wire logic SLOW_OSC_INPUT_I,
  input wire logic [7:0] COUNTER_INCREMENT_I,
  input wire logic [5:0] SECONDS_I,
  input wire logic [5:0] MINUTES_I,
  input wire logic [4:0] HOURS_I,
  input wire logic [4:0] MONTH_DAY_I,
  input wire logic [2:0] WEEK_DAY_I,
  input wire logic [8:0] YEAR_DAY_I,
  input wire logic [3:0] MONTH_I,
  input wire logic [11:0] YEAR_I,
  input wire logic [5:0] ALARM_SECONDS_I,
  input wire logic [5:0] ALARM_MINUTES_I,
  input wire logic [4:0] ALARM_HOURS_I,
  input wire logic [4:0] ALARM_MONTH_DAY_I,
  input wire logic [2:0] ALARM_WEEK_DAY_I,
  input wire logic [8:0] ALARM_YEAR_DAY_I,
  input wire logic [3:0] ALARM_MONTH_I,
  input wire logic [11:0] ALARM_YEAR_I,
  output logic COUNTER_RUN_ENABLE_O,
  output logic SECOND_TICK_O,
  output logic [1:0] FACTORY_TEST_FIELD_O,
  output logic RTC_IRQ_O
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [31:0] addr;
  logic [31:0] next_addr;
  logic wr_pend;
  logic next_wr_pend;
  logic rd_pend;
  logic next_rd_pend;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic [rtc_pkg::CONTROL_W-1:0] control;
  logic [rtc_pkg::CONTROL_W-1:0] next_control;
  logic [7:0] irq_enable;
  logic [7:0] next_irq_enable;
  logic [7:0] mask;
  logic [7:0] next_mask;
  logic [rtc_pkg::FLAGS_W-1:0] flags;
  logic [rtc_pkg::FLAGS_W-1:0] next_flags;
  logic [rtc_pkg::TICK_W-1:0] tick;
  logic [rtc_pkg::TICK_W-1:0] next_tick;
  logic second;
  logic next_second;

  logic accept;
  logic inc_event;
  logic tick_en;
  logic [rtc_pkg::FLAGS_W-1:0] flag_clear;
  logic [31:0] read_value;
  logic [31:0] packed_time_low;
  logic [31:0] packed_date;
  logic [31:0] packed_year_day;

  alarm_link_if lnk ();

  // Address match used by the read mux, the write decode and the checks
  function automatic logic hit(input logic [31:0] a, input logic [31:0] t);
    return a == t;
  endfunction : hit

  // ----------------------------------------------------------------
  // Alarm comparator
  // ----------------------------------------------------------------
  assign lnk.now_val[0] = 12'(SECONDS_I);
  assign lnk.now_val[1] = 12'(MINUTES_I);
  assign lnk.now_val[2] = 12'(HOURS_I);
  assign lnk.now_val[3] = 12'(MONTH_DAY_I);
  assign lnk.now_val[4] = 12'(WEEK_DAY_I);
  assign lnk.now_val[5] = 12'(YEAR_DAY_I);
  assign lnk.now_val[6] = 12'(MONTH_I);
  assign lnk.now_val[7] = YEAR_I;
  assign lnk.al_val[0] = 12'(ALARM_SECONDS_I);
  assign lnk.al_val[1] = 12'(ALARM_MINUTES_I);
  assign lnk.al_val[2] = 12'(ALARM_HOURS_I);
  assign lnk.al_val[3] = 12'(ALARM_MONTH_DAY_I);
  assign lnk.al_val[4] = 12'(ALARM_WEEK_DAY_I);
  assign lnk.al_val[5] = 12'(ALARM_YEAR_DAY_I);
  assign lnk.al_val[6] = 12'(ALARM_MONTH_I);
  assign lnk.al_val[7] = ALARM_YEAR_I;
  assign lnk.mask = mask;

  alarm_compare u_alarm (
    .clk_i(REF_CLK_I),
    .rst_n_i(RST_N_I),
    .lnk(lnk.cmp)
  );

  // ----------------------------------------------------------------
  // Packed time words, reserved bits read as zero
  // ----------------------------------------------------------------
  always_comb begin
    packed_time_low = 32'h0000_0000;
    packed_date = 32'h0000_0000;
    packed_year_day = 32'h0000_0000;
    packed_time_low[rtc_pkg::SEC_LSB +: rtc_pkg::SEC_W] = SECONDS_I;
    packed_time_low[rtc_pkg::MIN_LSB +: rtc_pkg::MIN_W] = MINUTES_I;
    packed_time_low[rtc_pkg::HOUR_LSB +: rtc_pkg::HOUR_W] = HOURS_I;
    packed_time_low[rtc_pkg::DOW_LSB +: rtc_pkg::DOW_W] = WEEK_DAY_I;
    packed_date[rtc_pkg::DOM_LSB +: rtc_pkg::DOM_W] = MONTH_DAY_I;
    packed_date[rtc_pkg::MON_LSB +: rtc_pkg::MON_W] = MONTH_I;
    packed_date[rtc_pkg::YEAR_LSB +: rtc_pkg::YEAR_W] = YEAR_I;
    packed_year_day[rtc_pkg::DOY_LSB +: rtc_pkg::DOY_W] = YEAR_DAY_I;
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    read_value = 32'h0000_0000;
    if (hit(addr, rtc_pkg::FLAGS_ADDR)) begin
      read_value = 32'(flags);
    end else if (hit(addr, rtc_pkg::TICK_COUNT_ADDR)) begin
      read_value = 32'(tick) << rtc_pkg::TICK_LSB;
    end else if (hit(addr, rtc_pkg::CONTROL_ADDR)) begin
      read_value = 32'(control);
    end else if (hit(addr, rtc_pkg::IRQ_ENABLE_ADDR)) begin
      read_value = 32'(irq_enable);
    end else if (hit(addr, rtc_pkg::MASK_ADDR)) begin
      read_value = 32'(mask);
    end else if (hit(addr, rtc_pkg::PACKED_TIME_LOW_ADDR)) begin
      read_value = packed_time_low;
    end else if (hit(addr, rtc_pkg::PACKED_DATE_ADDR)) begin
      read_value = packed_date;
    end else if (hit(addr, rtc_pkg::PACKED_YEAR_DAY_ADDR)) begin
      read_value = packed_year_day;
    end
  end

  // ----------------------------------------------------------------
  // Bus slave: writes take no wait, reads take one wait state
  // ----------------------------------------------------------------
  always_comb begin
    accept = HSEL_I && HTRANS_I[1] && HREADY_I;
    next_addr = accept ? HADDR_I : addr;
    next_wr_pend = accept && HWRITE_I && (HSIZE_I == rtc_pkg::WORD_SIZE);
    next_rd_pend = accept && !HWRITE_I;
    next_rdata = rd_pend ? read_value : rdata;
  end

  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      addr <= 32'h0000_0000;
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      rdata <= 32'h0000_0000;
    end else begin
      addr <= next_addr;
      wr_pend <= next_wr_pend;
      rd_pend <= next_rd_pend;
      rdata <= next_rdata;
    end
  end

  assign HREADYOUT_O = !rd_pend;
  assign HRESP_O = 1'b0;
  assign HRDATA_O = rdata;

  // ----------------------------------------------------------------
  // Control registers and interrupt source flags
  // ----------------------------------------------------------------
  always_comb begin
    next_control = control;
    next_irq_enable = irq_enable;
    next_mask = mask;
    flag_clear = '0;
    // Packed words have no write path
    if (wr_pend) begin
      if (hit(addr, rtc_pkg::CONTROL_ADDR)) begin
        next_control = HWDATA_I[rtc_pkg::CONTROL_W-1:0];
      end
      if (hit(addr, rtc_pkg::IRQ_ENABLE_ADDR)) begin
        next_irq_enable = HWDATA_I[7:0];
      end
      if (hit(addr, rtc_pkg::MASK_ADDR)) begin
        next_mask = HWDATA_I[7:0];
      end
      if (hit(addr, rtc_pkg::FLAGS_ADDR)) begin
        flag_clear = HWDATA_I[rtc_pkg::FLAGS_W-1:0];
      end
    end
    inc_event = |(COUNTER_INCREMENT_I & irq_enable);
    // A new event wins over a clear in the same cycle
    next_flags[rtc_pkg::FLAG_INC_BIT] = inc_event ||
      (flags[rtc_pkg::FLAG_INC_BIT] && !flag_clear[rtc_pkg::FLAG_INC_BIT]);
    next_flags[rtc_pkg::FLAG_ALARM_BIT] = lnk.rise ||
      (flags[rtc_pkg::FLAG_ALARM_BIT] && !flag_clear[rtc_pkg::FLAG_ALARM_BIT]);
  end

  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      control <= rtc_pkg::CONTROL_RESET;
      irq_enable <= rtc_pkg::IRQ_ENABLE_RESET;
      mask <= rtc_pkg::MASK_RESET;
      flags <= '0;
    end else begin
      control <= next_control;
      irq_enable <= next_irq_enable;
      mask <= next_mask;
      flags <= next_flags;
    end
  end

  assign COUNTER_RUN_ENABLE_O = control[rtc_pkg::RUN_ENABLE_BIT];
  assign FACTORY_TEST_FIELD_O = control[rtc_pkg::TEST_FIELD_LSB +: rtc_pkg::TEST_FIELD_W];
  assign RTC_IRQ_O = |flags;

  // ----------------------------------------------------------------
  // Sub-second tick counter and seconds strobe
  // ----------------------------------------------------------------
  always_comb begin
    tick_en = control[rtc_pkg::SOURCE_SELECT_BIT] ? SLOW_OSC_INPUT_I : PRESCALE_TICK_I;
    next_tick = tick;
    next_second = 1'b0;
    if (control[rtc_pkg::TICK_CLEAR_BIT]) begin
      next_tick = '0;
    end else if (control[rtc_pkg::RUN_ENABLE_BIT] && tick_en) begin
      next_tick = tick + 15'h0001;
      next_second = tick == rtc_pkg::TICK_LAST;
    end
  end

  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      tick <= '0;
      second <= 1'b0;
    end else begin
      tick <= next_tick;
      second <= next_second;
    end
  end

  assign SECOND_TICK_O = second;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!RST_N_I);

  stopped_hold_a: assert property (!control[0] && !control[1] |=> $stable(tick) && !SECOND_TICK_O)
    else $error("Tick advanced while counters stopped");
  run_stops_a: assert property (!COUNTER_RUN_ENABLE_O [*2] |-> !SECOND_TICK_O)
    else $error("Seconds strobe while run enable low");
  tick_clear_a: assert property (control[1] |=> tick == 15'h0000)
    else $error("Tick counter not held clear");
  source_gate_a: assert property (control[4] && !control[1] && !SLOW_OSC_INPUT_I |=> $stable(tick))
    else $error("Tick counted without the selected source");
  control_write_a: assert property (wr_pend && hit(addr, rtc_pkg::CONTROL_ADDR)
    |=> control == $past(HWDATA_I[4:0]))
    else $error("Control write not stored");
  inc_event_a: assert property (|(COUNTER_INCREMENT_I & irq_enable) |=> flags[0] && RTC_IRQ_O)
    else $error("Enabled increment did not raise flag");
  inc_hold_a: assert property (flags[0] && !(wr_pend && hit(addr, rtc_pkg::FLAGS_ADDR) && HWDATA_I[0])
    |=> flags[0])
    else $error("Increment flag dropped without a clear");
  alarm_set_a: assert property (lnk.rise |=> flags[1] && RTC_IRQ_O)
    else $error("Alarm edge did not raise flag");
  alarm_hold_a: assert property (flags[1] && !(wr_pend && hit(addr, rtc_pkg::FLAGS_ADDR) && HWDATA_I[1])
    |=> flags[1])
    else $error("Alarm flag dropped without a clear");
  flag_clear_a: assert property (wr_pend && hit(addr, rtc_pkg::FLAGS_ADDR) && HWDATA_I[1] && !lnk.rise
    |=> !flags[1])
    else $error("Alarm flag not cleared by a one");
  time_pack_a: assert property (rd_pend && hit(addr, rtc_pkg::PACKED_TIME_LOW_ADDR)
    |=> HRDATA_O[20:16] == $past(HOURS_I) && HRDATA_O[13:8] == $past(MINUTES_I))
    else $error("Packed time word misplaced fields");
  date_pack_a: assert property (rd_pend && hit(addr, rtc_pkg::PACKED_DATE_ADDR)
    |=> HRDATA_O[27:16] == $past(YEAR_I) && HRDATA_O[11:8] == $past(MONTH_I))
    else $error("Packed date word misplaced fields");
  year_day_a: assert property (rd_pend && hit(addr, rtc_pkg::PACKED_YEAR_DAY_ADDR)
    |=> HRDATA_O[11:0] == 12'($past(YEAR_DAY_I)))
    else $error("Packed year day word wrong");

  second_c: cover property (SECOND_TICK_O);
  both_flags_c: cover property (flags == 2'b11);
  date_read_c: cover property (rd_pend && hit(addr, rtc_pkg::PACKED_DATE_ADDR));
  clear_then_run_c: cover property (control[1] ##1 !control[1] && control[0]);

endmodule : rtc_control

// *** tb.sv ***
// Self-checking bench for the calendar clock control block
`timescale 1ns/1ns
module tb;
  logic clk;
  logic rst_n;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic hready;
  logic hresp;
  logic pre_tick;
  logic slow_tick;
  logic [7:0] inc;
  rtc_pkg::value_t now_v [8];
  rtc_pkg::value_t al_v [8];
  logic run_en;
  logic sec_tick;
  logic [1:0] test_field;
  logic irq;
  logic [31:0] rd;
  int fail_count;
  int compares;
  int sec_cnt;
  int s0;

  rtc_control i_rtc_control (
    .REF_CLK_I(clk), .RST_N_I(rst_n), .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans),
    .HWRITE_I(hwrite), .HSIZE_I(rtc_pkg::WORD_SIZE), .HWDATA_I(hwdata), .HREADY_I(hready),
    .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp),
    .PRESCALE_TICK_I(pre_tick), .SLOW_OSC_INPUT_I(slow_tick), .COUNTER_INCREMENT_I(inc),
    .SECONDS_I(now_v[0][5:0]), .MINUTES_I(now_v[1][5:0]), .HOURS_I(now_v[2][4:0]),
    .MONTH_DAY_I(now_v[3][4:0]), .WEEK_DAY_I(now_v[4][2:0]), .YEAR_DAY_I(now_v[5][8:0]),
    .MONTH_I(now_v[6][3:0]), .YEAR_I(now_v[7]),
    .ALARM_SECONDS_I(al_v[0][5:0]), .ALARM_MINUTES_I(al_v[1][5:0]), .ALARM_HOURS_I(al_v[2][4:0]),
    .ALARM_MONTH_DAY_I(al_v[3][4:0]), .ALARM_WEEK_DAY_I(al_v[4][2:0]), .ALARM_YEAR_DAY_I(al_v[5][8:0]),
    .ALARM_MONTH_I(al_v[6][3:0]), .ALARM_YEAR_I(al_v[7]),
    .COUNTER_RUN_ENABLE_O(run_en), .SECOND_TICK_O(sec_tick), .FACTORY_TEST_FIELD_O(test_field),
    .RTC_IRQ_O(irq)
  );

  // ----------------------------------------------------------------
  // Clock, second pulse counter and watchdog
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Counts second pulses leaving the tick divider
  always @(posedge clk) begin
    if (sec_tick === 1'b1) sec_cnt <= sec_cnt + 1;
  end

  // Cuts a hang short well beyond the expected run of about 33500 cycles
  initial begin
    repeat (90000) @(posedge clk);
    fail_count++;
    wrap_up();
  end

  // ----------------------------------------------------------------
  // Bus and check tasks
  // ----------------------------------------------------------------
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  // Samples ready just before the edge, so the value is the one the edge sees
  task automatic wait_ready();
    int n;
    n = 0;
    @(negedge clk);
    while (hready !== 1'b1 && n < 50) begin
      n++;
      @(negedge clk);
    end
    if (n >= 50) check("bus ready", {31'h0, hready}, 32'h0000_0001);
    rd = hrdata;
    @(posedge clk);
  endtask : wait_ready

  // One single word transfer: address phase, then data phase
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= wr;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_ready();
  endtask : bus

  task automatic rchk(input string nm, input logic [31:0] a, input logic [31:0] m, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    check(nm, rd & m, exp);
  endtask : rchk

  // Pulses the prescaler or the slow oscillator enable n times
  task automatic ticks(input logic slow, input int n);
    repeat (n) begin
      @(posedge clk);
      if (slow) slow_tick <= 1'b1;
      else pre_tick <= 1'b1;
      @(posedge clk);
      slow_tick <= 1'b0;
      pre_tick <= 1'b0;
    end
  endtask : ticks

  task automatic pulse_inc(input logic [7:0] m);
    @(posedge clk);
    inc <= m;
    @(posedge clk);
    inc <= 8'h00;
  endtask : pulse_inc

  task automatic wrap_up();
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : wrap_up

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = 32'h0000_0000;
    pre_tick = 1'b0;
    slow_tick = 1'b0;
    inc = 8'h00;
    fail_count = 0;
    compares = 0;
    sec_cnt = 0;
    for (int k = 0; k < 8; k++) begin
      now_v[k] = 12'h000;
      al_v[k] = 12'h001;
    end
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    // Register defaults, width of the control register, unmapped place
    rchk("control reset", rtc_pkg::CONTROL_ADDR, 32'hFFFF_FFFF, 32'h0000_0000);
    rchk("enable reset", rtc_pkg::IRQ_ENABLE_ADDR, 32'hFFFF_FFFF, 32'h0000_0000);
    rchk("mask reset", rtc_pkg::MASK_ADDR, 32'hFFFF_FFFF, 32'h0000_0000);
    rchk("unmapped", 32'hE002_4040, 32'hFFFF_FFFF, 32'h0000_0000);
    // Upper bits set, factory test field kept at zero
    bus(1'b1, rtc_pkg::CONTROL_ADDR, 32'hFFFF_FFF3);
    rchk("control width", rtc_pkg::CONTROL_ADDR, 32'hFFFF_FFFF, 32'h0000_0013);
    check("run out", {31'h0, run_en}, 32'h0000_0001);
    check("test field out", {30'h0, test_field}, 32'h0000_0000);
    bus(1'b1, rtc_pkg::IRQ_ENABLE_ADDR, 32'h0000_00A5);
    rchk("enable rw", rtc_pkg::IRQ_ENABLE_ADDR, 32'hFFFF_FFFF, 32'h0000_00A5);
    bus(1'b1, rtc_pkg::MASK_ADDR, 32'h0000_005A);
    rchk("mask rw", rtc_pkg::MASK_ADDR, 32'hFFFF_FFFF, 32'h0000_005A);
    $display("test registers done");
    // Tick clear, source select and run freeze
    bus(1'b1, rtc_pkg::CONTROL_ADDR, 32'h0000_0003);
    ticks(1'b0, 4);
    rchk("tick held clear", rtc_pkg::TICK_COUNT_ADDR, 32'h0000_FFFE, 32'h0000_0000);
    bus(1'b1, rtc_pkg::CONTROL_ADDR, 32'h0000_0001);
    ticks(1'b0, 5);
    ticks(1'b1, 3);
    rchk("tick prescaler", rtc_pkg::TICK_COUNT_ADDR, 32'h0000_FFFE, 32'h0000_000A);
    bus(1'b1, rtc_pkg::CONTROL_ADDR, 32'h0000_0011);
    ticks(1'b1, 3);
    ticks(1'b0, 2);
    rchk("tick slow osc", rtc_pkg::TICK_COUNT_ADDR, 32'h0000_FFFE, 32'h0000_0010);
    bus(1'b1, rtc_pkg::CONTROL_ADDR, 32'h0000_0010);
    ticks(1'b1, 4);
    rchk("tick frozen", rtc_pkg::TICK_COUNT_ADDR, 32'h0000_FFFE, 32'h0000_0010);
    check("run off out", {31'h0, run_en}, 32'h0000_0000);
    bus(1'b1, rtc_pkg::CONTROL_ADDR, 32'h0000_0003);
    bus(1'b1, rtc_pkg::CONTROL_ADDR, 32'h0000_0001);
    s0 = sec_cnt;
    @(posedge clk);
    pre_tick <= 1'b1;
    repeat (32768) @(posedge clk);
    pre_tick <= 1'b0;
    repeat (3) @(posedge clk);
    check("second pulses", sec_cnt - s0, 32'h0000_0001);
    $display("test tick divider done");
    // Increment events, each counter enabled alone and disabled alone
    for (int i = 0; i < 8; i++) begin
      bus(1'b1, rtc_pkg::IRQ_ENABLE_ADDR, {24'h0, ~(8'h01 << i)});
      pulse_inc(8'h01 << i);
      rchk("inc disabled", rtc_pkg::FLAGS_ADDR, 32'h0000_0003, 32'h0000_0000);
      bus(1'b1, rtc_pkg::IRQ_ENABLE_ADDR, {24'h0, 8'h01 << i});
      pulse_inc(8'h01 << i);
      rchk("inc flag", rtc_pkg::FLAGS_ADDR, 32'h0000_0003, 32'h0000_0001);
      bus(1'b1, rtc_pkg::FLAGS_ADDR, 32'h0000_0002);
      rchk("inc flag kept", rtc_pkg::FLAGS_ADDR, 32'h0000_0003, 32'h0000_0001);
      check("irq up", {31'h0, irq}, 32'h0000_0001);
      bus(1'b1, rtc_pkg::FLAGS_ADDR, 32'h0000_0001);
      rchk("inc cleared", rtc_pkg::FLAGS_ADDR, 32'h0000_0003, 32'h0000_0000);
      check("irq down", {31'h0, irq}, 32'h0000_0000);
    end
    $display("test increment events done");
    // Alarm: one counter compared at a time, the others mismatching
    for (int i = 0; i < 8; i++) begin
      bus(1'b1, rtc_pkg::MASK_ADDR, {24'h0, ~(8'h01 << i)});
      @(posedge clk);
      now_v[i] <= 12'h001;
      rchk("alarm flag", rtc_pkg::FLAGS_ADDR, 32'h0000_0003, 32'h0000_0002);
      bus(1'b1, rtc_pkg::FLAGS_ADDR, 32'h0000_0001);
      rchk("alarm kept", rtc_pkg::FLAGS_ADDR, 32'h0000_0003, 32'h0000_0002);
      bus(1'b1, rtc_pkg::FLAGS_ADDR, 32'h0000_0002);
      repeat (4) @(posedge clk);
      rchk("alarm once", rtc_pkg::FLAGS_ADDR, 32'h0000_0003, 32'h0000_0000);
      bus(1'b1, rtc_pkg::MASK_ADDR, 32'h0000_0000);
      rchk("alarm unmasked", rtc_pkg::FLAGS_ADDR, 32'h0000_0003, 32'h0000_0000);
      @(posedge clk);
      now_v[i] <= 12'h000;
    end
    bus(1'b1, rtc_pkg::MASK_ADDR, 32'h0000_00FF);
    @(posedge clk);
    now_v[0] <= 12'h001;
    repeat (3) @(posedge clk);
    now_v[0] <= 12'h000;
    rchk("alarm disabled", rtc_pkg::FLAGS_ADDR, 32'h0000_0003, 32'h0000_0000);
    $display("test alarm done");
    // Packed words and their read-only nature
    @(posedge clk);
    now_v <= '{12'h02B, 12'h03A, 12'h017, 12'h01F, 12'h006, 12'h16D, 12'h00C, 12'hABC};
    for (int p = 0; p < 2; p++) begin
      rchk("packed time", rtc_pkg::PACKED_TIME_LOW_ADDR, 32'h071F_3F3F, 32'h0617_3A2B);
      rchk("packed date", rtc_pkg::PACKED_DATE_ADDR, 32'h0FFF_0F1F, 32'h0ABC_0C1F);
      rchk("packed day", rtc_pkg::PACKED_YEAR_DAY_ADDR, 32'h0000_0FFF, 32'h0000_016D);
      bus(1'b1, rtc_pkg::PACKED_TIME_LOW_ADDR, 32'h0000_0000);
      bus(1'b1, rtc_pkg::PACKED_DATE_ADDR, 32'h0000_0000);
      bus(1'b1, rtc_pkg::PACKED_YEAR_DAY_ADDR, 32'h0000_0000);
    end
    check("bus response", {31'h0, hresp}, 32'h0000_0000);
    $display("test packed words done");
    wrap_up();
  end
endmodule : tb
